// ===== rsr_map.vh
// Register offsets, field positions, reset values and timing for the reset source recorder.
// Included by the recorder's top module; holds definitions only.
`ifndef RSR_MAP_VH
`define RSR_MAP_VH

// Register byte offsets on the AXI4-Lite slave
`define RSR_OFF_CAUSE      8'h00
`define RSR_OFF_LVD_CTRL   8'h04
`define RSR_OFF_LVD_LEVEL  8'h08
`define RSR_OFF_WDT_EN     8'h0C
`define RSR_OFF_EVT_STAT   8'h10
`define RSR_OFF_EVT_MASK   8'h14
`define RSR_OFF_SEQ_STAT   8'h18

// Register select codes returned by the address decoder
`define RSR_SEL_CAUSE      3'h0
`define RSR_SEL_LVD_CTRL   3'h1
`define RSR_SEL_LVD_LEVEL  3'h2
`define RSR_SEL_WDT_EN     3'h3
`define RSR_SEL_EVT_STAT   3'h4
`define RSR_SEL_EVT_MASK   3'h5
`define RSR_SEL_SEQ_STAT   3'h6
`define RSR_SEL_NONE       3'h7

// Field positions in the cause register
`define RSR_CAUSE_WDT_BIT  4
`define RSR_CAUSE_LVD_BIT  0

// Field positions in the event status and mask registers
`define RSR_EVT_PIN_BIT    0
`define RSR_EVT_PWR_BIT    1
`define RSR_EVT_WDT_BIT    2
`define RSR_EVT_LVD_BIT    3

// Reset values
`define RSR_RST_CAUSE      8'h00
`define RSR_RST_LVD        8'h00
`define RSR_RST_WDT_EN_LO  8'h1A
`define RSR_RST_WDT_EN_HI  8'h9A
`define RSR_RST_EVT        4'h0
`define RSR_RST_MASK       4'h0

// AXI response codes
`define RSR_RESP_OKAY      2'b00
`define RSR_RESP_SLVERR    2'b10

// Timing: clock period and oscillation stabilization wait
`define RSR_CLK_PERIOD_NS  100
`define RSR_OSC_WAIT_NS    6400
`define RSR_OSC_WAIT_CYC   ((`RSR_OSC_WAIT_NS + `RSR_CLK_PERIOD_NS - 1) / `RSR_CLK_PERIOD_NS)

`endif

// ===== rsr_sync2.v
// Two flip-flop synchroniser for the recorder's external inputs.
// Assumes the inputs are asynchronous to I_CLOCK; the first stage feeds only the second.
module rsr_sync2 #(
    parameter [4:0] RST_VAL = 5'h00
) (
    input  wire       i_clk,
    input  wire       i_rst_n,
    input  wire [4:0] i_async,
    output reg  [4:0] o_sync
);
    reg [4:0] meta_r;

    // Two stages, reset to the idle level of each input
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta_r <= RST_VAL;
            o_sync <= RST_VAL;
        end else begin
            meta_r <= i_async;
            o_sync <= meta_r;
        end
    end
endmodule

// ===== rsr_top.v
// Reset source recorder: sequences the internal reset, records its cause and
// keeps or clears the low-voltage registers per source and reloads the watchdog enable from the strap on every reset.
// Assumes reset requests arrive asynchronously and software uses AXI4-Lite.
// Function
// R01: Only PC undefined; state held during reset
// R02: Watchdog flag: clear pin/power-on, set watchdog, hold low-voltage
// R03: Low-voltage flag: hold on watchdog, set on low-voltage
// R04: Low-voltage registers cleared except on low-voltage reset
// R05: Watchdog enable reset value picked by option strap
// R06: Cause register zero after pin/power-on and on read
`include "rsr_map.vh"
module rsr_top (
    input  wire        I_CLOCK,
    input  wire        I_RESET_N,
    input  wire        I_PIN_RESET_N,
    input  wire        I_PWR_CLR_REQ,
    input  wire        I_WDT_REQ,
    input  wire        I_LVD_REQ,
    input  wire        I_WDT_OPT,
    input  wire [7:0]  I_AWADDR,
    input  wire        I_AWVALID,
    output reg         O_AWREADY,
    input  wire [31:0] I_WDATA,
    input  wire [3:0]  I_WSTRB,
    input  wire        I_WVALID,
    output reg         O_WREADY,
    output reg  [1:0]  O_BRESP,
    output reg         O_BVALID,
    input  wire        I_BREADY,
    input  wire [7:0]  I_ARADDR,
    input  wire        I_ARVALID,
    output reg         O_ARREADY,
    output reg  [31:0] O_RDATA,
    output reg  [1:0]  O_RRESP,
    output reg         O_RVALID,
    input  wire        I_RREADY,
    output reg         O_SYS_RESET_N,
    output reg         O_PC_UNDEFINED,
    output reg  [7:0]  O_LVD_CONTROL,
    output reg  [7:0]  O_LVD_LEVEL,
    output reg  [7:0]  O_WDT_ENABLE,
    output reg         O_IRQ
);
    localparam [2:0]  ST_RUN   = 3'b001;
    localparam [2:0]  ST_RESET = 3'b010;
    localparam [2:0]  ST_WAIT  = 3'b100;
    localparam [31:0] WAIT_FULL = `RSR_OSC_WAIT_CYC - 1;
    localparam [11:0] WAIT_LAST = WAIT_FULL[11:0]; // Counter is 12 bits wide

    wire [4:0]  sync_w;
    reg  [2:0]  state_r;
    reg  [2:0]  state_nxt;
    reg  [11:0] wait_cnt_r;
    reg  [3:0]  req_prev_r;
    reg         wdt_flag_r;
    reg         lvd_flag_r;
    reg  [3:0]  evt_stat_r;
    reg  [3:0]  evt_mask_r;
    reg  [3:0]  evt_stat_nxt;
    reg  [7:0]  aw_addr_r;
    reg  [31:0] w_data_r;
    reg  [3:0]  w_strb_r;
    reg         aw_full_r;
    reg         w_full_r;

    // Synchronised requests: pin reset active low, others active high
    wire        pin_req  = ~sync_w[0];
    wire        pwr_clr_req = sync_w[1];
    wire        wdt_req  = sync_w[2];
    wire        lvd_req  = sync_w[3];
    wire        opt_sync = sync_w[4];
    wire        any_req  = pin_req | pwr_clr_req | wdt_req | lvd_req;
    wire        hard_req = pin_req | pwr_clr_req;
    wire [3:0]  req_vec  = {lvd_req, wdt_req, pwr_clr_req, pin_req};
    wire [3:0]  req_rise = req_vec & ~req_prev_r;

    // Bus events
    wire        ar_take  = I_ARVALID & O_ARREADY;
    wire        wr_do    = aw_full_r & w_full_r & ~O_BVALID;
    wire [2:0]  rd_sel   = rsr_decode(I_ARADDR);
    wire [2:0]  wr_sel   = rsr_decode(aw_addr_r);
    wire        wr_ok    = wr_do & (state_r == ST_RUN) & (wr_sel != `RSR_SEL_NONE);
    wire        wr_lane0 = wr_ok & w_strb_r[0];
    wire        rd_clr_cause = ar_take & (rd_sel == `RSR_SEL_CAUSE);
    wire        rd_clr_evt   = ar_take & (rd_sel == `RSR_SEL_EVT_STAT);

    // Maps a byte address onto a register select code
    function [2:0] rsr_decode;
        input [7:0] addr;
        begin
            case (addr)
                `RSR_OFF_CAUSE:     rsr_decode = `RSR_SEL_CAUSE;
                `RSR_OFF_LVD_CTRL:  rsr_decode = `RSR_SEL_LVD_CTRL;
                `RSR_OFF_LVD_LEVEL: rsr_decode = `RSR_SEL_LVD_LEVEL;
                `RSR_OFF_WDT_EN:    rsr_decode = `RSR_SEL_WDT_EN;
                `RSR_OFF_EVT_STAT:  rsr_decode = `RSR_SEL_EVT_STAT;
                `RSR_OFF_EVT_MASK:  rsr_decode = `RSR_SEL_EVT_MASK;
                `RSR_OFF_SEQ_STAT:  rsr_decode = `RSR_SEL_SEQ_STAT;
                default:            rsr_decode = `RSR_SEL_NONE;
            endcase
        end
    endfunction

    // Request and strap inputs cross into the clock domain
    rsr_sync2 #(
        .RST_VAL (5'h01)
    ) u_sync (
        .i_clk   (I_CLOCK),
        .i_rst_n (I_RESET_N),
        .i_async ({I_WDT_OPT, I_LVD_REQ, I_WDT_REQ, I_PWR_CLR_REQ, I_PIN_RESET_N}),
        .o_sync  (sync_w)
    );

    // Reset sequence: hold while any request, then stabilization wait
    always @* begin
        case (state_r)
            ST_RUN:   state_nxt = any_req ? ST_RESET : ST_RUN;
            ST_RESET: state_nxt = any_req ? ST_RESET : ST_WAIT;
            ST_WAIT: begin
                if (any_req) begin
                    state_nxt = ST_RESET;
                end else if (wait_cnt_r == WAIT_LAST) begin
                    state_nxt = ST_RUN;
                end else begin
                    state_nxt = ST_WAIT;
                end
            end
            default:  state_nxt = ST_RESET;
        endcase
    end

    // Sequencer registers; PC marked undefined outside the run state
    always @(posedge I_CLOCK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            state_r        <= ST_WAIT;
            wait_cnt_r     <= 12'h000;
            req_prev_r     <= 4'h0;
            O_SYS_RESET_N  <= 1'b0;
            O_PC_UNDEFINED <= 1'b1;
        end else begin
            state_r        <= state_nxt;
            req_prev_r     <= req_vec;
            wait_cnt_r     <= (state_r == ST_WAIT && state_nxt == ST_WAIT) ?
                              wait_cnt_r + 12'h001 : 12'h000;
            O_SYS_RESET_N  <= (state_nxt == ST_RUN);
            O_PC_UNDEFINED <= (state_nxt != ST_RUN); // R01
        end
    end

    // Cause flags; a hardware set wins over a read clear
    always @(posedge I_CLOCK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            wdt_flag_r <= 1'b0;
            lvd_flag_r <= 1'b0;
        end else if (hard_req) begin
            wdt_flag_r <= 1'b0; // R02
            lvd_flag_r <= 1'b0; // R06
        end else begin
            if (wdt_req) begin
                wdt_flag_r <= 1'b1; // R02
            end else if (rd_clr_cause) begin
                wdt_flag_r <= 1'b0; // R06
            end
            if (lvd_req) begin
                lvd_flag_r <= 1'b1; // R03
            end else if (rd_clr_cause) begin
                lvd_flag_r <= 1'b0; // R06
            end
        end
    end

    // Low-voltage registers kept across low-voltage resets only
    always @(posedge I_CLOCK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            O_LVD_CONTROL <= `RSR_RST_LVD;
            O_LVD_LEVEL   <= `RSR_RST_LVD;
        end else if (hard_req | wdt_req) begin
            O_LVD_CONTROL <= `RSR_RST_LVD; // R04
            O_LVD_LEVEL   <= `RSR_RST_LVD; // R04
        end else if (wr_lane0) begin
            if (wr_sel == `RSR_SEL_LVD_CTRL) begin
                O_LVD_CONTROL <= w_data_r[7:0];
            end
            if (wr_sel == `RSR_SEL_LVD_LEVEL) begin
                O_LVD_LEVEL <= w_data_r[7:0];
            end
        end
    end

    // Watchdog enable reloads from the strap while reset is in progress
    always @(posedge I_CLOCK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            O_WDT_ENABLE <= `RSR_RST_WDT_EN_LO;
        end else if (state_r != ST_RUN || any_req) begin
            O_WDT_ENABLE <= opt_sync ? `RSR_RST_WDT_EN_HI : `RSR_RST_WDT_EN_LO; // R05
        end else if (wr_lane0 && wr_sel == `RSR_SEL_WDT_EN) begin
            O_WDT_ENABLE <= w_data_r[7:0];
        end
    end

    // Next event status: new request edges set, a read clears
    always @* begin
        evt_stat_nxt = rd_clr_evt ? `RSR_RST_EVT : evt_stat_r;
        evt_stat_nxt = evt_stat_nxt | req_rise;
    end

    // Event status, mask and interrupt level
    always @(posedge I_CLOCK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            evt_stat_r <= `RSR_RST_EVT;
            evt_mask_r <= `RSR_RST_MASK;
            O_IRQ      <= 1'b0;
        end else begin
            evt_stat_r <= evt_stat_nxt;
            if (wr_lane0 && wr_sel == `RSR_SEL_EVT_MASK) begin
                evt_mask_r <= w_data_r[3:0];
                O_IRQ      <= |(evt_stat_nxt & w_data_r[3:0]);
            end else begin
                O_IRQ      <= |(evt_stat_nxt & evt_mask_r);
            end
        end
    end

    // Write channel: address and data taken in either order
    always @(posedge I_CLOCK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            O_AWREADY <= 1'b1;
            O_WREADY  <= 1'b1;
            O_BVALID  <= 1'b0;
            O_BRESP   <= `RSR_RESP_OKAY;
            aw_full_r <= 1'b0;
            w_full_r  <= 1'b0;
            aw_addr_r <= 8'h00;
            w_data_r  <= 32'h0000_0000;
            w_strb_r  <= 4'h0;
        end else begin
            if (I_AWVALID && O_AWREADY) begin
                aw_addr_r <= I_AWADDR;
                aw_full_r <= 1'b1;
                O_AWREADY <= 1'b0;
            end
            if (I_WVALID && O_WREADY) begin
                w_data_r <= I_WDATA;
                w_strb_r <= I_WSTRB;
                w_full_r <= 1'b1;
                O_WREADY <= 1'b0;
            end
            if (wr_do) begin
                O_BVALID <= 1'b1;
                // Writes refused while reset holds the registers
                O_BRESP  <= wr_ok ? `RSR_RESP_OKAY : `RSR_RESP_SLVERR; // R01
            end else if (O_BVALID && I_BREADY) begin
                O_BVALID  <= 1'b0;
                aw_full_r <= 1'b0;
                w_full_r  <= 1'b0;
                O_AWREADY <= 1'b1;
                O_WREADY  <= 1'b1;
            end
        end
    end

    // Read channel: data one cycle after the address is taken
    always @(posedge I_CLOCK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            O_ARREADY <= 1'b1;
            O_RVALID  <= 1'b0;
            O_RRESP   <= `RSR_RESP_OKAY;
            O_RDATA   <= 32'h0000_0000;
        end else if (ar_take) begin
            O_ARREADY <= 1'b0;
            O_RVALID  <= 1'b1;
            O_RRESP   <= (rd_sel == `RSR_SEL_NONE) ? `RSR_RESP_SLVERR : `RSR_RESP_OKAY;
            case (rd_sel)
                `RSR_SEL_CAUSE: begin
                    O_RDATA <= 32'h0000_0000;
                    O_RDATA[`RSR_CAUSE_WDT_BIT] <= wdt_flag_r;
                    O_RDATA[`RSR_CAUSE_LVD_BIT] <= lvd_flag_r;
                end
                `RSR_SEL_LVD_CTRL:  O_RDATA <= {24'h00_0000, O_LVD_CONTROL};
                `RSR_SEL_LVD_LEVEL: O_RDATA <= {24'h00_0000, O_LVD_LEVEL};
                `RSR_SEL_WDT_EN:    O_RDATA <= {24'h00_0000, O_WDT_ENABLE};
                `RSR_SEL_EVT_STAT:  O_RDATA <= {28'h000_0000, evt_stat_r};
                `RSR_SEL_EVT_MASK:  O_RDATA <= {28'h000_0000, evt_mask_r};
                `RSR_SEL_SEQ_STAT:  O_RDATA <= {29'h000_0000, state_r};
                default:            O_RDATA <= 32'h0000_0000;
            endcase
        end else if (O_RVALID && I_RREADY) begin
            O_RVALID  <= 1'b0;
            O_ARREADY <= 1'b1;
        end
    end
endmodule

// ===== rsr_chk.sv
// Checker for the reset source recorder, watching only the top-level ports.
// Assumes one clock and an asynchronous active-low block reset.
module rsr_chk (
    input wire       I_CLOCK,
    input wire       I_RESET_N,
    input wire       I_PIN_RESET_N,
    input wire       I_PWR_CLR_REQ,
    input wire       I_WDT_REQ,
    input wire       I_LVD_REQ,
    input wire       O_BVALID,
    input wire [1:0] O_BRESP,
    input wire       O_SYS_RESET_N,
    input wire       O_PC_UNDEFINED,
    input wire [7:0] O_LVD_CONTROL,
    input wire [7:0] O_LVD_LEVEL,
    input wire [7:0] O_WDT_ENABLE,
    input wire       O_IRQ
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge I_CLOCK); endclocking
    default disable iff (!I_RESET_N);
    reg [7:0] low_cnt_r;
    // Counts cycles spent in reset or wait, saturating
    always @(posedge I_CLOCK or negedge I_RESET_N) begin
        if (!I_RESET_N)
            low_cnt_r <= 8'h00;
        else if (O_SYS_RESET_N)
            low_cnt_r <= 8'h00;
        else if (low_cnt_r != 8'hFF)
            low_cnt_r <= low_cnt_r + 8'h01;
    end
    a_pc_tracks: assert property (O_PC_UNDEFINED == !O_SYS_RESET_N)
        else $error("pc flag disagrees with system reset");
    a_wait_length: assert property ($rose(O_SYS_RESET_N) |-> low_cnt_r >= 8'h40)
        else $error("system reset released before the wait ended");
    a_write_refused: assert property ($rose(O_BVALID) && !$past(O_SYS_RESET_N) |-> O_BRESP == 2'h2)
        else $error("write accepted while in reset");
    a_wdt_clears_lvd: assert property (I_WDT_REQ [*4] |=> O_LVD_CONTROL == 8'h00 && O_LVD_LEVEL == 8'h00)
        else $error("watchdog reset left low-voltage registers set");
    a_pin_clears_lvd: assert property ((!I_PIN_RESET_N || I_PWR_CLR_REQ) [*4] |=> O_LVD_CONTROL == 8'h00)
        else $error("pin or power-on reset left low-voltage control set");
    a_lvd_keeps_regs: assert property ((I_LVD_REQ && !I_WDT_REQ && !I_PWR_CLR_REQ && I_PIN_RESET_N) [*4]
        |=> $stable(O_LVD_CONTROL) && $stable(O_LVD_LEVEL)) else $error("low-voltage reset lost its registers");
    a_wdt_en_value: assert property (!O_SYS_RESET_N |=> O_WDT_ENABLE == 8'h1A || O_WDT_ENABLE == 8'h9A)
        else $error("watchdog enable not at a reset value");
    cover property ($rose(O_SYS_RESET_N));
    cover property ($rose(O_IRQ));
    cover property (O_WDT_ENABLE == 8'h9A);
endmodule

// ===== rsr_src_model.sv
// Model of the reset request sources facing the recorder.
// Assumes the bench pulses i_go for one cycle with the source code in i_kind.
module rsr_src_model (
    input  wire logic       i_clk,
    input  wire logic       i_go,
    input  wire logic [2:0] i_kind,
    output logic            o_pin_reset_n,
    output logic            o_pwr_clr_req,
    output logic            o_wdt_req,
    output logic            o_lvd_req
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] kind_r = 3'h0;
    logic [3:0] left_r = 4'h0;
    // Holds the chosen request for eight cycles, then releases every line
    always @(posedge i_clk) begin
        if (i_go) begin
            kind_r <= i_kind;
            left_r <= 4'h8;
        end else if (left_r != 4'h0) begin
            left_r <= left_r - 4'h1;
        end
    end
    // Codes: 1 pin, 2 power-on, 3 watchdog, 4 low-voltage, 5 watchdog and low-voltage
    assign o_pin_reset_n = !(left_r != 4'h0 && kind_r == 3'h1);
    assign o_pwr_clr_req = left_r != 4'h0 && kind_r == 3'h2;
    assign o_wdt_req     = left_r != 4'h0 && (kind_r == 3'h3 || kind_r == 3'h5);
    assign o_lvd_req     = left_r != 4'h0 && (kind_r == 3'h4 || kind_r == 3'h5);
endmodule

// ===== reset_source_recorder_test.sv
// Self-checking bench for the reset source recorder.
// Assumes rsr_top with its AXI4-Lite slave and the request source model beside it.
module reset_source_recorder_test;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {logic [2:0] kind; logic opt; logic rd; logic [7:0] cause; logic [7:0] lvd;} rsr_row_t;
    logic clk = 1'b0, rst_n = 1'b0, opt = 1'b0, go = 1'b0;
    logic [2:0] kind = 3'h0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000, data;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [1:0] resp;
    wire pin_n, pclr, wdt, lvd, awready, wready, bvalid, arready, rvalid, sys_n, pc_u, irq;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire [7:0] lvd_ctl, lvd_lvl, wdt_en;
    int n_fail = 0, check_count = 0;
    rsr_row_t rows [11] = '{'{3'h3, 1'b1, 1'b1, 8'h10, 8'h00}, '{3'h4, 1'b0, 1'b1, 8'h01, 8'h55},
        '{3'h3, 1'b0, 1'b0, 8'h00, 8'h00}, '{3'h4, 1'b1, 1'b1, 8'h11, 8'h55},
        '{3'h4, 1'b0, 1'b0, 8'h00, 8'h55}, '{3'h3, 1'b0, 1'b1, 8'h11, 8'h00},
        '{3'h3, 1'b1, 1'b0, 8'h00, 8'h00}, '{3'h1, 1'b0, 1'b1, 8'h00, 8'h00},
        '{3'h4, 1'b1, 1'b0, 8'h00, 8'h55}, '{3'h2, 1'b0, 1'b1, 8'h00, 8'h00},
        '{3'h5, 1'b1, 1'b1, 8'h11, 8'h00}};
    always #50 clk = ~clk;
    rsr_src_model u_src (.i_clk(clk), .i_go(go), .i_kind(kind), .o_pin_reset_n(pin_n),
        .o_pwr_clr_req(pclr), .o_wdt_req(wdt), .o_lvd_req(lvd));
    rsr_top dut (.I_CLOCK(clk), .I_RESET_N(rst_n), .I_PIN_RESET_N(pin_n), .I_PWR_CLR_REQ(pclr),
        .I_WDT_REQ(wdt), .I_LVD_REQ(lvd), .I_WDT_OPT(opt), .I_AWADDR(awaddr), .I_AWVALID(awvalid),
        .O_AWREADY(awready), .I_WDATA(wdata), .I_WSTRB(4'hF), .I_WVALID(wvalid), .O_WREADY(wready),
        .O_BRESP(bresp), .O_BVALID(bvalid), .I_BREADY(bready), .I_ARADDR(araddr),
        .I_ARVALID(arvalid), .O_ARREADY(arready), .O_RDATA(rdata), .O_RRESP(rresp),
        .O_RVALID(rvalid), .I_RREADY(rready), .O_SYS_RESET_N(sys_n), .O_PC_UNDEFINED(pc_u),
        .O_LVD_CONTROL(lvd_ctl), .O_LVD_LEVEL(lvd_lvl), .O_WDT_ENABLE(wdt_en), .O_IRQ(irq));
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic give_up(input string what);
        chk(what, 32'h0000_0000, 32'h0000_0001);
        tally_and_finish();
    endtask
    // Write with address and data offered together, response taken when it comes
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        bit done;
        n = 0;
        done = 1'b0;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!done && n < 100) begin
            @(posedge clk);
            n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid === 1'b1) begin
                resp = bresp;
                bready <= 1'b0;
                done = 1'b1;
            end
        end
        if (!done) give_up("write timeout");
    endtask
    task automatic rd(input logic [7:0] a);
        int n;
        bit done;
        n = 0;
        done = 1'b0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!done && n < 100) begin
            @(posedge clk);
            n++;
            if (arready) arvalid <= 1'b0;
            if (rvalid === 1'b1) begin
                data = rdata;
                resp = rresp;
                rready <= 1'b0;
                done = 1'b1;
            end
        end
        if (!done) give_up("read timeout");
    endtask
    task automatic wait_sys(input logic v);
        int n;
        n = 0;
        while (sys_n !== v && n < 300) begin
            @(posedge clk);
            n++;
        end
        if (sys_n !== v) give_up("system reset timeout");
    endtask
    // Power-up checks, then the row table, then the interrupt path
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        chk("pc flag in reset", pc_u, 32'h1);
        chk("lvd control at reset", lvd_ctl, 32'h0);
        chk("watchdog enable at reset", wdt_en, 32'h1A);
        wr(8'h04, 32'h0000_0077);
        chk("write during wait", resp, 32'h2);
        wait_sys(1'b1);
        chk("lvd control kept", lvd_ctl, 32'h0);
        rd(8'h00);
        chk("cause after power-up", data, 32'h0);
        rd(8'h1C);
        chk("unmapped read", resp, 32'h2);
        chk("unmapped read data", data, 32'h0);
        $display("power-up test done");
        foreach (rows[i]) begin
            opt <= rows[i].opt;
            wr(8'h04, 32'h0000_0055);
            wr(8'h08, 32'h0000_0055);
            wr(8'h0C, 32'h0000_0033);
            chk("write response", resp, 32'h0);
            chk("watchdog enable written", wdt_en, 32'h33);
            kind <= rows[i].kind;
            go <= 1'b1;
            @(posedge clk);
            go <= 1'b0;
            wait_sys(1'b0);
            chk("pc flag during reset", pc_u, 32'h1);
            wait_sys(1'b1);
            chk("lvd control", lvd_ctl, rows[i].lvd);
            chk("lvd level", lvd_lvl, rows[i].lvd);
            chk("watchdog enable", wdt_en, rows[i].opt ? 32'h9A : 32'h1A);
            if (rows[i].rd) begin
                rd(8'h00);
                chk("cause", data, rows[i].cause);
                rd(8'h00);
                chk("cause after read", data, 32'h0);
            end
            $display("row %0d done", i);
        end
        chk("irq masked", irq, 32'h0);
        wr(8'h14, 32'h0000_0008);
        repeat (2) @(posedge clk);
        chk("irq raised", irq, 32'h1);
        rd(8'h10);
        chk("event status", data, 32'hF);
        rd(8'h14);
        chk("mask readback", data, 32'h8);
        repeat (2) @(posedge clk);
        chk("irq cleared", irq, 32'h0);
        $display("interrupt test done");
        // Block reset in mid-run clears the written low-voltage register
        wr(8'h04, 32'h0000_0066);
        chk("lvd control written", lvd_ctl, 32'h66);
        rst_n <= 1'b0;
        @(posedge clk);
        chk("pc flag in block reset", pc_u, 32'h1);
        chk("lvd control in block reset", lvd_ctl, 32'h0);
        chk("irq in block reset", irq, 32'h0);
        rst_n <= 1'b1;
        wait_sys(1'b1);
        chk("watchdog enable strap", wdt_en, 32'h9A);
        rd(8'h00);
        chk("cause after block reset", data, 32'h0);
        rd(8'h18);
        chk("sequencer in run", data, 32'h1);
        $display("block reset test done");
        tally_and_finish();
    end
endmodule
bind rsr_top rsr_chk u_chk (.I_CLOCK(I_CLOCK), .I_RESET_N(I_RESET_N), .I_PIN_RESET_N(I_PIN_RESET_N),
    .I_PWR_CLR_REQ(I_PWR_CLR_REQ), .I_WDT_REQ(I_WDT_REQ), .I_LVD_REQ(I_LVD_REQ), .O_BVALID(O_BVALID),
    .O_BRESP(O_BRESP), .O_SYS_RESET_N(O_SYS_RESET_N), .O_PC_UNDEFINED(O_PC_UNDEFINED),
    .O_LVD_CONTROL(O_LVD_CONTROL), .O_LVD_LEVEL(O_LVD_LEVEL), .O_WDT_ENABLE(O_WDT_ENABLE), .O_IRQ(O_IRQ));
